// file: verilog/small_float_format_codec.sv
// small float codec: half words to single, unsigned 11-bit words to and from single,
// plus a single multiplier, in a two-stage fixed-latency pipeline
// assumes requests come from logic on the same clock, no back-pressure
//
// Functional notes
// - half is sign, 5-bit exponent, 10-bit mantissa
// - half bit 15 sign, 14:10 exponent, 9:0 mantissa
// - half zero, denormal, normal, inf, nan decode
// - any half input accepted, never hangs
// - uf11 is unsigned, 5-bit exponent, 6-bit mantissa
// - uf11 upper five bits exponent, lower six mantissa
// - uf11 zero, denormal, normal, inf, nan decode
// - uf11 encode rounds nearest, or toward zero
// - uf11 encode: negatives zero, clamp at 65024
// - uf11 encode: -inf zero, +inf inf, nan positive
// - any uf11 input accepted, never hangs
// - internal arithmetic accurate to one in 1e5
// - internal range at least two to 32
// - times zero zero, times one identity; the multiplier flushes denormal singles, so a denormal times one gives zero
// - inf and nan internally are optional
// - division by zero never halts processing
module small_float_format_codec
  import sffc_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // request
  input wire logic in_valid,
  input wire op_t in_op,
  input wire logic round_to_zero,
  input wire logic [31:0] in_a,
  input wire logic [31:0] in_b,
  // answer
  output logic out_valid,
  output op_t out_op,
  output logic [31:0] out_data
);

  // whole pipeline state
  typedef struct packed {
    logic s1_v;           // stage one holds a request
    op_t s1_op;
    logic s1_rtz;         // round toward zero for this request
    logic [31:0] s1_a;
    logic [31:0] s1_b;
    logic out_v;          // answer valid
    op_t out_op;
    logic [31:0] out_data;
  } state_t;

  state_t st_q;           // registered state
  state_t st_d;           // next state
  logic [31:0] mul_p;     // product of stage one operands

  // decode a 5-bit-exponent word, mantissa left-aligned to 10 bits;
  // uf11 pads its six bits with zeros, so M/64 equals 16M/1024
  function automatic logic [31:0] dec_small(input logic s,
                                            input logic [4:0] e,
                                            input logic [9:0] m);
    logic [31:0] r;
    logic [9:0] mn;
    int p;
    r = {s, 31'h0000_0000};   // signed zero by default
    mn = m;
    p = 0;
    if (e == EXP5_MAX) begin
      // inf keeps its sign, nan keeps a nonzero fraction
      r = {s, F32_EXP_MAX, m, 13'h0000};
    end else if (e != 5'h00) begin
      r = {s, {3'b000, e} + EXP5_BIAS_ADJ, m, 13'h0000};
    end else if (m != 10'h000) begin
      // denormal: 2^-14 * m / 1024, renormalised as a single
      for (int i = 0; i < HALF_MANT_W; i++) begin
        if (m[i]) begin
          p = i;
        end
      end
      mn = m << (HALF_MANT_W - p);  // leading one drops off the top
      r = {s, 8'(p) + DEN_EXP_BASE, mn, 13'h0000};
    end
    return r;
  endfunction : dec_small

  // encode a single into an unsigned 11-bit word
  function automatic logic [10:0] enc_uf11(input logic [31:0] a,
                                           input logic rtz);
    logic [10:0] r;
    logic [10:0] q;
    logic [7:0] e;
    logic [49:0] ext;
    logic inc;
    int sh;
    e = a[F32_EXP_LSB +: F32_EXP_W];
    r = 11'h000;
    q = 11'h000;
    ext = '0;
    inc = 1'b0;
    sh = 0;
    if (is_nan(a)) begin
      r = UF11_NAN;                       // either sign
    end else if (a[F32_SIGN_POS]) begin
      r = 11'h000;                        // -inf and negatives
    end else if (e == F32_EXP_MAX) begin
      r = UF11_INF;
    end else if (e >= ENC_SAT_EXP) begin
      r = UF11_MAX;
    end else if (e >= ENC_NORM_MIN) begin
      q = {5'(e - EXP5_BIAS_ADJ), a[F32_MANT_W-1 -: UF11_MANT_W]};
      inc = !rtz && rne(q[0], a[16], |a[15:0]);
      // rounding past the largest finite would make inf; clamp
      r = (q == UF11_MAX && inc) ? UF11_MAX : q + 11'(inc);
    end else if (e != 8'h00) begin
      // result is a uf11 denormal; a carry into 64 lands on the
      // smallest normal code, which is exactly the right value
      sh = ENC_DEN_BASE - int'(e);
      if (sh <= ENC_SH_MAX) begin
        ext = {1'b1, a[F32_MANT_W-1:0], 26'h000_0000} >> sh;
        q = 11'(ext[49:26]);
        inc = !rtz && rne(q[0], ext[25], |ext[24:0]);
        r = q + 11'(inc);
      end
    end
    return r;
  endfunction : enc_uf11

  // multiplier on the stage one operands, single precision
  fp32_mul u_mul (
    .a(st_q.s1_a),
    .b(st_q.s1_b),
    .p(mul_p)
  );

  // next state: stage one captures, stage two computes and holds
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.s1_v = in_valid;
      st_d.s1_op = in_op;
      st_d.s1_rtz = round_to_zero;
      st_d.s1_a = in_a;
      st_d.s1_b = in_b;
      st_d.out_v = st_q.s1_v;
      if (st_q.s1_v) begin
        st_d.out_op = st_q.s1_op;
        // every op finishes in one pass, nothing can wait
        case (st_q.s1_op)
          OP_HALF_DEC: begin
            st_d.out_data = dec_small(st_q.s1_a[HALF_SIGN_POS],
                st_q.s1_a[HALF_EXP_LSB +: EXP5_W],
                st_q.s1_a[HALF_MANT_W-1:0]);
          end
          OP_UF11_DEC: begin
            st_d.out_data = dec_small(1'b0,
                st_q.s1_a[UF11_EXP_LSB +: EXP5_W],
                {st_q.s1_a[UF11_MANT_W-1:0], 4'h0});
          end
          OP_UF11_ENC: begin
            st_d.out_data = {21'h00_0000,
                             enc_uf11(st_q.s1_a, st_q.s1_rtz)};
          end
          OP_MUL: begin
            st_d.out_data = mul_p;
          end
          default: begin
            st_d.out_data = RST_WORD;
          end
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{s1_v: 1'b0, s1_op: OP_HALF_DEC, s1_rtz: 1'b0,
                s1_a: RST_WORD, s1_b: RST_WORD, out_v: 1'b0,
                out_op: OP_HALF_DEC, out_data: RST_WORD};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign out_valid = st_q.out_v;
  assign out_op = st_q.out_op;
  assign out_data = st_q.out_data;

  // checks on the pipeline and the conversions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // request taken is answered two enabled edges later
  a_fixed_latency_valid: assert property (
    (in_valid && clk_en ##1 clk_en) |=> out_valid)
    else $error("request lost in pipeline");

  // no answer without a request
  a_no_spurious_valid: assert property (
    (!st_q.s1_v && clk_en) |=> !out_valid)
    else $error("answer without request");

  // frozen while enable low
  a_enable_freeze: assert property (
    !clk_en |=> $stable(out_data) && $stable(out_valid))
    else $error("state moved while disabled");

  // half signed zero
  a_half_zero_sign: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_HALF_DEC &&
     st_q.s1_a[14:0] == 15'h0000) |=>
    out_data == {$past(st_q.s1_a[HALF_SIGN_POS]), 31'h0000_0000})
    else $error("half zero decoded wrong");

  // half normal fields carried over with rebias
  a_half_normal_map: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_HALF_DEC &&
     st_q.s1_a[14:10] != 5'h00 && st_q.s1_a[14:10] != EXP5_MAX) |=>
    out_data[22:13] == $past(st_q.s1_a[9:0]) &&
    out_data[30:23] == {3'b000, $past(st_q.s1_a[14:10])} + 8'h70 &&
    out_data[31] == $past(st_q.s1_a[15]))
    else $error("half normal decoded wrong");

  // uf11 infinity
  a_uf11_dec_inf: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_DEC &&
     st_q.s1_a[10:0] == UF11_INF) |=> out_data == 32'h7F80_0000)
    else $error("uf11 inf decoded wrong");

  // negative finite encodes as zero
  a_enc_neg_zero: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_ENC &&
     st_q.s1_a[31] && !is_nan(st_q.s1_a)) |=> out_data == 32'h0000_0000)
    else $error("negative not encoded as zero");

  // large positive clamps to 65024
  a_enc_clamp_max: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_ENC &&
     !st_q.s1_a[31] && st_q.s1_a[30:23] >= 8'h8F &&
     st_q.s1_a[30:23] != 8'hFF) |=> out_data == 32'h0000_07BF)
    else $error("large value not clamped");

  // nan of either sign encodes as positive nan
  a_enc_nan_pos: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_ENC &&
     is_nan(st_q.s1_a)) |=> out_data == 32'h0000_07E0)
    else $error("nan not encoded as positive nan");

  // times one leaves a normal value unchanged
  a_mul_by_one: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_MUL &&
     st_q.s1_b == F32_ONE && st_q.s1_a[30:23] != 8'h00 &&
     st_q.s1_a[30:23] != 8'hFF) |=> out_data == $past(st_q.s1_a))
    else $error("times one changed value");

  // times zero gives zero
  a_mul_by_zero: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_MUL &&
     st_q.s1_b[30:0] == 31'h0000_0000 && st_q.s1_a[30:23] != 8'hFF) |=>
    out_data[30:0] == 31'h0000_0000)
    else $error("times zero not zero");

  // uf11 decode never gives a negative single
  a_uf11_dec_unsigned: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_DEC) |=>
    !out_data[F32_SIGN_POS])
    else $error("uf11 decoded as negative");

  // half denormal lands from 2^-24 up to below the smallest normal half exponent, 2^-14
  a_half_denorm_range: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_HALF_DEC &&
     st_q.s1_a[14:10] == 5'h00 && st_q.s1_a[9:0] != 10'h000) |=>
    out_data[30:23] >= DEN_EXP_BASE && out_data[30:23] < ENC_NORM_MIN)
    else $error("half denormal out of range");

  // half inf and nan keep an all-ones exponent and their fraction
  a_half_special_map: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_HALF_DEC &&
     st_q.s1_a[14:10] == EXP5_MAX) |=>
    out_data[30:23] == F32_EXP_MAX &&
    out_data[22:13] == $past(st_q.s1_a[9:0]))
    else $error("half inf or nan decoded wrong");

  // encode result sits in the low eleven bits only
  a_enc_upper_clear: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_ENC) |=>
    out_data[31:UF11_W] == 21'h00_0000)
    else $error("encode set upper bits");

  // positive infinity encodes as infinity
  a_enc_pos_inf: assert property (
    (clk_en && st_q.s1_v && st_q.s1_op == OP_UF11_ENC &&
     st_q.s1_a == 32'h7F80_0000) |=> out_data[10:0] == UF11_INF)
    else $error("positive inf not encoded as inf");

  // an answer carries the op of its own request, keeping order
  a_out_op_follows: assert property (
    (clk_en && st_q.s1_v) |=> out_op == $past(st_q.s1_op))
    else $error("answer op does not match request");

  // main scenarios
  c_half_dec: cover property (clk_en && st_q.s1_v &&
                              st_q.s1_op == OP_HALF_DEC);
  c_uf11_enc_round: cover property (clk_en && st_q.s1_v &&
      st_q.s1_op == OP_UF11_ENC && !st_q.s1_rtz);
  c_back_to_back: cover property (out_valid && clk_en ##1 out_valid);
  c_freeze_hold: cover property (out_valid && !clk_en);
  c_mul_op: cover property (clk_en && st_q.s1_v && st_q.s1_op == OP_MUL);

endmodule : small_float_format_codec

// file: common/sffc_pkg.sv
// constants, types and helpers shared by the small float codec files
// assumes a single clock domain; nothing here holds state
package sffc_pkg;

  // operation select on the request port
  typedef enum logic [1:0] {
    OP_HALF_DEC = 2'h0,  // 16-bit half word to single
    OP_UF11_DEC = 2'h1,  // unsigned 11-bit word to single
    OP_UF11_ENC = 2'h2,  // single to unsigned 11-bit word
    OP_MUL = 2'h3        // single times single
  } op_t;

  // half word layout
  localparam int HALF_SIGN_POS = 15;
  localparam int HALF_EXP_LSB = 10;
  localparam int HALF_MANT_W = 10;
  localparam int EXP5_W = 5;
  // unsigned 11-bit word layout
  localparam int UF11_EXP_LSB = 6;
  localparam int UF11_MANT_W = 6;
  localparam int UF11_W = 11;
  // single layout
  localparam int F32_SIGN_POS = 31;
  localparam int F32_EXP_LSB = 23;
  localparam int F32_EXP_W = 8;
  localparam int F32_MANT_W = 23;

  // exponent figures
  localparam logic [4:0] EXP5_MAX = 5'h1F;
  localparam logic [7:0] F32_EXP_MAX = 8'hFF;
  localparam logic [7:0] EXP5_BIAS_ADJ = 8'h70;  // 127 - 15
  localparam logic [7:0] DEN_EXP_BASE = 8'h67;   // 127 - 24
  localparam logic [7:0] ENC_SAT_EXP = 8'h8F;    // 2^16 and above
  localparam logic [7:0] ENC_NORM_MIN = 8'h71;   // 2^-14
  localparam int ENC_DEN_BASE = 130;              // shift base
  localparam int ENC_SH_MAX = 25;
  localparam logic [9:0] MUL_BIAS = 10'h07F;
  localparam logic [9:0] MUL_OVF = 10'h17E;      // 127 + 255

  // special codes
  localparam logic [10:0] UF11_MAX = 11'h7BF;    // 65024
  localparam logic [10:0] UF11_INF = 11'h7C0;
  localparam logic [10:0] UF11_NAN = 11'h7E0;
  localparam logic [31:0] F32_QNAN = 32'h7FC0_0000;
  localparam logic [31:0] F32_ONE = 32'h3F80_0000;

  // pipeline figures and reset value
  localparam int PIPE_LATENCY = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // single is nan: all-ones exponent, nonzero fraction
  function automatic logic is_nan(input logic [31:0] f);
    return (f[F32_EXP_LSB +: F32_EXP_W] == F32_EXP_MAX) &&
           (f[F32_MANT_W-1:0] != '0);
  endfunction : is_nan

  // round to nearest, ties to even
  function automatic logic rne(input logic lsb, input logic g,
                               input logic st);
    return g & (st | lsb);
  endfunction : rne

endpackage : sffc_pkg

// file: verilog/fp32_mul.sv
// single precision multiplier, purely combinational
// assumes the caller registers both operands and the product
module fp32_mul
  import sffc_pkg::*;
(
  // operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // product
  output logic [31:0] p
);

  logic s;            // product sign
  logic [7:0] ea;     // biased exponents
  logic [7:0] eb;
  logic [47:0] prod;  // full significand product
  logic [9:0] exs;    // exponent sum, still biased twice
  logic [22:0] mant;  // kept fraction
  logic g;            // guard bit
  logic st;           // sticky bit
  logic [30:0] body;  // exponent and fraction before rounding

  // denormal singles count as zero: flushing keeps the datapath
  // short, and halves never decode to a single denormal anyway
  always_comb begin
    s = a[F32_SIGN_POS] ^ b[F32_SIGN_POS];
    ea = a[F32_EXP_LSB +: F32_EXP_W];
    eb = b[F32_EXP_LSB +: F32_EXP_W];
    // widen both significands first so the product keeps all 48 bits
    prod = 48'({1'b1, a[F32_MANT_W-1:0]}) *
           48'({1'b1, b[F32_MANT_W-1:0]});
    exs = {2'b00, ea} + {2'b00, eb} + {9'h000, prod[47]};
    // normalise: product lies in [1,4)
    if (prod[47]) begin
      mant = prod[46:24];
      g = prod[23];
      st = |prod[22:0];
    end else begin
      mant = prod[45:23];
      g = prod[22];
      st = |prod[21:0];
    end
    body = {8'(exs - MUL_BIAS), mant};
    if (is_nan(a) || is_nan(b)) begin
      p = F32_QNAN;
    end else if (ea == F32_EXP_MAX || eb == F32_EXP_MAX) begin
      // inf times zero has no value; give nan, never stall
      p = (ea == 8'h00 || eb == 8'h00) ? F32_QNAN
                                       : {s, F32_EXP_MAX, 23'h00_0000};
    end else if (ea == 8'h00 || eb == 8'h00) begin
      p = {s, 31'h0000_0000};  // x times zero is zero
    end else if (exs >= MUL_OVF) begin
      p = {s, F32_EXP_MAX, 23'h00_0000};
    end else if (exs <= MUL_BIAS) begin
      p = {s, 31'h0000_0000};  // underflow flushes
    end else begin
      // carry out of the fraction bumps the exponent, even into inf
      p = {s, body + 31'(rne(mant[0], g, st))};
    end
  end

endmodule : fp32_mul

// file: verif/answer_sink.sv
// downstream stage model: takes every answer the codec presents
// assumes one clock; no back-pressure exists, so it never stalls
module answer_sink
  import sffc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // answer from the codec
  input wire logic out_valid,
  input wire op_t out_op,
  input wire logic [31:0] out_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // answers in arrival order, read by the bench
  logic [33:0] got_q[$];

  // take on enabled edges only; a frozen valid must not count twice
  always @(posedge clock) begin
    if (rst_n && clk_en && out_valid) begin
      got_q.push_back({out_op, out_data});
    end
  end
endmodule : answer_sink

// file: verif/small_float_format_codec_tb.sv
// self-checking bench for the small float codec
// assumes answers come two enabled edges after a request, in order
module small_float_format_codec_tb
  import sffc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // clock, reset and request drive
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic in_valid = 1'b0;
  op_t in_op = OP_HALF_DEC;
  logic round_to_zero = 1'b0;
  logic [31:0] in_a = 32'h0;
  logic [31:0] in_b = 32'h0;
  // answer side
  logic out_valid;
  op_t out_op;
  logic [31:0] out_data;
  // expected answers and tallies
  logic [33:0] exp_q[$];
  int num_errors = 0;
  int check_count = 0;

  // 25 MHz clock
  always #20 clock = ~clock;

  // device under test
  small_float_format_codec u_small_float_format_codec (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .in_valid(in_valid), .in_op(in_op), .round_to_zero(round_to_zero),
    .in_a(in_a), .in_b(in_b),
    .out_valid(out_valid), .out_op(out_op), .out_data(out_data));

  // consumer of the answers
  answer_sink u_answer_sink (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .out_valid(out_valid), .out_op(out_op), .out_data(out_data));

  // compare an answer word with its op
  task automatic check_ans(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_ans

  // compare a single flag
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  // one request per edge; leaves in_valid high for back to back use
  task automatic issue(input op_t op, input logic [31:0] a,
                       input logic [31:0] b, input logic rtz,
                       input logic [31:0] res);
    in_valid = 1'b1;
    in_op = op;
    in_a = a;
    in_b = b;
    round_to_zero = rtz;
    exp_q.push_back({op, res});
    @(posedge clock);
    #1;
  endtask : issue

  // wait bounded for all answers, then match them in order
  task automatic drain(input string name);
    logic [33:0] e;
    in_valid = 1'b0;
    for (int i = 0; i < 20; i++) begin
      if (u_answer_sink.got_q.size() >= exp_q.size()) break;
      @(posedge clock);
    end
    // a few more edges so a spurious extra answer shows up
    repeat (3) @(posedge clock);
    #1;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      // a missing answer must fail whatever value was expected
      if (u_answer_sink.got_q.size() == 0) begin
        check_ans('x, e);
      end else begin
        check_ans(u_answer_sink.got_q.pop_front(), e);
      end
    end
    check_bit(u_answer_sink.got_q.size() == 0, 1'b1);
    u_answer_sink.got_q.delete();
    $display("test %s done", name);
  endtask : drain

  // half words: negative zero, denormals, normals, inf, nan, junk upper bits
  task automatic t_half();
    logic [31:0] v[10][2] = '{'{32'h0000_3C00, 32'h3F80_0000},
      '{32'h0000_8000, 32'h8000_0000}, '{32'h0000_0001, 32'h3380_0000},
      '{32'h0000_03FF, 32'h387F_C000}, '{32'h0000_7BFF, 32'h477F_E000},
      '{32'h0000_FC00, 32'hFF80_0000}, '{32'h0000_0400, 32'h3880_0000},
      '{32'hFFFF_3C00, 32'h3F80_0000}, '{32'h0000_7E00, 32'h7FC0_0000},
      '{32'h0000_C000, 32'hC000_0000}};
    foreach (v[i]) begin
      issue(OP_HALF_DEC, v[i][0], 32'h0, 1'b0,
            v[i][1]);
    end
    drain("half decode");
  endtask : t_half

  // unsigned 11-bit words decoded to single
  task automatic t_uf11_dec();
    logic [31:0] v[7][2] = '{'{32'h0000_03C0, 32'h3F80_0000},
      '{32'h0000_0001, 32'h3580_0000}, '{32'h0000_07BF, 32'h477E_0000},
      '{32'h0000_07C0, 32'h7F80_0000}, '{32'h0000_0041, 32'h3882_0000},
      '{32'hFFFF_FBC0, 32'h3F80_0000}, '{32'h0000_0000, 32'h0000_0000}};
    foreach (v[i]) begin
      issue(OP_UF11_DEC, v[i][0], 32'h0, 1'b0,
            v[i][1]);
    end
    drain("uf11 decode");
  endtask : t_uf11_dec

  // single to unsigned 11-bit: rounding, clamps, specials
  task automatic t_uf11_enc();
    logic [31:0] v[15][3] = '{'{32'h477E_0000, 0, 32'h0000_07BF},
      '{32'h4974_2400, 0, 32'h0000_07BF}, '{32'h477F_F000, 0, 32'h0000_07BF},
      '{32'h477F_F000, 1, 32'h0000_07BF}, '{32'hBF80_0000, 0, 32'h0},
      '{32'h8000_0000, 0, 32'h0}, '{32'h7F80_0000, 0, 32'h0000_07C0},
      '{32'hFF80_0000, 0, 32'h0}, '{32'hFFC0_0000, 0, 32'h0000_07E0},
      '{32'h7FC0_0000, 0, 32'h0000_07E0}, '{32'h3F83_0000, 0, 32'h0000_03C2},
      '{32'h3F83_0000, 1, 32'h0000_03C1}, '{32'h3F81_0000, 0, 32'h0000_03C0},
      '{32'h3F80_0000, 1, 32'h0000_03C0}, '{32'h3580_0000, 0, 32'h0000_0001}};
    foreach (v[i]) begin
      issue(OP_UF11_ENC, v[i][0], 32'h0, v[i][1][0],
            v[i][2]);
    end
    drain("uf11 encode");
  endtask : t_uf11_enc

  // products: identities and a wide range result
  task automatic t_mul();
    logic [31:0] v[7][3] = '{'{32'h4000_0000, 32'h4040_0000, 32'h40C0_0000},
      '{32'h4040_0000, 32'h0, 32'h0}, '{32'hC040_0000, 32'h0, 32'h8000_0000},
      '{32'h3FAA_AAAB, 32'h3F80_0000, 32'h3FAA_AAAB},
      '{32'h3F80_0000, 32'hC2F6_E979, 32'hC2F6_E979},
      '{32'h4980_0000, 32'h4980_0000, 32'h5380_0000}, '{32'h0, 32'h0, 32'h0}};
    foreach (v[i]) begin
      issue(OP_MUL, v[i][0], v[i][1], 1'b0,
            v[i][2]);
    end
    drain("multiply");
  endtask : t_mul

  // latency counted in enabled edges; a frozen valid stays up
  task automatic t_latency();
    issue(OP_MUL, F32_ONE, F32_ONE, 1'b0, F32_ONE);
    in_valid = 1'b0;
    clk_en = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check_bit(out_valid, 1'b0);
    clk_en = 1'b1;
    @(posedge clock);
    #1;
    check_bit(out_valid, 1'b1);
    // a frozen answer stays up and must still be taken only once
    clk_en = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check_bit(out_valid, 1'b1);
    clk_en = 1'b1;
    @(posedge clock);
    #1;
    check_bit(out_valid, 1'b0);
    drain("latency");
  endtask : t_latency

  // reset with a request in flight drops it, then work resumes
  task automatic t_reset();
    issue(OP_HALF_DEC, 32'h0000_3C00, 32'h0, 1'b0, F32_ONE);
    void'(exp_q.pop_back());
    rst_n = 1'b0;
    in_valid = 1'b0;
    #2;
    check_ans({out_op, out_data}, 34'h0);
    check_bit(out_valid, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    issue(OP_UF11_DEC, 32'h0000_07C0, 32'h0, 1'b0, 32'h7F80_0000);
    drain("reset");
  endtask : t_reset

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_half();
    t_uf11_dec();
    t_uf11_enc();
    t_mul();
    t_latency();
    t_reset();
    summarize();
  end

  // watchdog: the tests need a few hundred cycles at most
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule : small_float_format_codec_tb
